// ==== hdl/pssc_pkg.sv ====
// package: register map, field layout and reset values of the strap/config bank
package pssc_pkg;
   localparam int          ADDR_W          = 8;
   localparam int          DATA_W          = 32;
   // word index of the configuration register; byte address is four times it
   localparam logic [7:0]  SYSCFG_IDX      = 8'h42;
   localparam logic [7:0]  STATUS_IDX      = 8'h43;
   // field positions inside system_configuration
   localparam int          GAIN0_LSB       = 0;
   localparam int          GAIN1_LSB       = 3;
   localparam int          CNVRST_LSB      = 8;
   localparam int          CNVSHDN_LSB     = 10;
   localparam int          REFTRIM_LSB     = 16;
   localparam int          AUTOTX_BIT      = 24;
   localparam logic [31:0] SYSCFG_RESET    = 32'h0042_0000;
   localparam logic [31:0] SYSCFG_WMASK    = 32'h01ff_0f3f;
   // status layout
   localparam int          STAT_IO_LSB     = 3;
   localparam int          STAT_ADDR_LSB   = 1;
   localparam int          STAT_MULTI_BIT  = 0;
   localparam logic [7:0]  STATUS_RESET    = 8'h00;
   // gain multipliers, binary log2 shift amount; highest defined code
   localparam logic [2:0]  GAIN_MAX_CODE   = 3'h5;
   typedef enum logic [1:0] {
      PSSC_IDLE   = 2'b00,
      PSSC_ANSWER = 2'b01
   } pssc_bus_t;
endpackage : pssc_pkg

// ==== hdl/pssc_gain_decode.sv ====
// gain field decoder: code to shift amount of the amplifier
module pssc_gain_decode
   import pssc_pkg::*;
(
   // field in
   input  wire logic [2:0] gainCode,
   // decoded log2 gain
   output logic      [2:0] gainShift
);
   // R6 undefined codes as one
   always_comb begin
      if (gainCode > GAIN_MAX_CODE) begin
         gainShift = 3'h0;
      end else begin
         gainShift = gainCode;
      end
   end
endmodule : pssc_gain_decode

// ==== hdl/pin_strap_status_and_sysconfig.sv ====
// strap status and system configuration register bank with avalon-mm slave
// Function
// R1: status bits 6..3 show live level of each input io pin
// R2: status bits 2..1 hold address strap pins latched at power-on
// R3: status bit 0 is 1 when mode pin was low at power-on
// R4: system configuration at 0x0042 holds gain, reset, shutdown, trim, auto-transmit
// R5: each of two channels has own three-bit gain field
// R6: gain codes 0..5 give 1..32; codes 110 and 111 give one
// R7: status is read-only; straps change only at power-on reset
module pin_strap_status_and_sysconfig
   import pssc_pkg::*;
(
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              nrst,
   // avalon-mm slave
   input  wire logic [ADDR_W-1:0] address,
   input  wire logic              read,
   input  wire logic              write,
   input  wire logic [3:0]        byteenable,
   input  wire logic [DATA_W-1:0] writedata,
   output logic      [DATA_W-1:0] readdata,
   output logic                   waitrequest,
   output logic      [1:0]        response,
   // device pins
   input  wire logic [3:0]        ioInputLevel,
   input  wire logic [1:0]        addrStrapPins,
   input  wire logic              modePin,
   // analog front end controls
   output logic      [2:0]        gainShiftCh0,
   output logic      [2:0]        gainShiftCh1,
   output logic      [1:0]        convResetCtl,
   output logic      [1:0]        convShutdownCtl,
   output logic      [7:0]        refTrim,
   output logic                   autoTxEnable
);
   logic [31:0] sysCfg_r, sysCfg_nxt;
   logic [3:0]  ioLevel_r, ioLevel_nxt;
   logic [1:0]  strap_r, strap_nxt;
   logic        multi_r, multi_nxt;
   logic        strapDone_r, strapDone_nxt;
   pssc_bus_t   bus_r, bus_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [1:0]  resp_r, resp_nxt;
   logic        waitReq_r, waitReq_nxt;
   logic [2:0]  gainCode [2];
   logic [2:0]  gainDec  [2];
   logic [31:0] statusWord;
   logic        reqHit;

   function automatic logic [31:0] be_mask(input logic [3:0] be);
      be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction : be_mask

   // address decode, used only by the checks; the bus logic decodes with its own case
   function automatic logic is_cfg(input logic [ADDR_W-1:0] a);
      is_cfg = (a == SYSCFG_IDX);
   endfunction : is_cfg

   function automatic logic is_status(input logic [ADDR_W-1:0] a);
      is_status = (a == STATUS_IDX);
   endfunction : is_status

   // R1 status assembly
   assign statusWord = {24'h0, 1'b0, ioLevel_r, strap_r, multi_r};
   assign reqHit     = (read | write) & (bus_r == PSSC_IDLE);

   // straps caught by clock after reset release, then frozen
   // limitation: strap pins must be steady for one cycle after release
   always_comb begin
      ioLevel_nxt   = ioInputLevel;
      strap_nxt     = strap_r;
      multi_nxt     = multi_r;
      strapDone_nxt = 1'b1;
      if (!strapDone_r) begin
         // R2 latch strap pins
         strap_nxt = addrStrapPins;
         // R3 low mode means multi
         multi_nxt = ~modePin;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ioLevel_r   <= 4'h0;
         strap_r     <= 2'h0;
         multi_r     <= 1'b0;
         strapDone_r <= 1'b0;
      end else begin
         ioLevel_r   <= ioLevel_nxt;
         strap_r     <= strap_nxt;
         multi_r     <= multi_nxt;
         strapDone_r <= strapDone_nxt;
      end
   end

   // bus: one wait cycle, answer on the second edge
   always_comb begin
      bus_nxt     = PSSC_IDLE;
      waitReq_nxt = 1'b1;
      sysCfg_nxt  = sysCfg_r;
      rdata_nxt  = rdata_r;
      resp_nxt   = resp_r;
      if (reqHit) begin
         // write lands on the taking edge; the master holds it to the answer
         bus_nxt     = PSSC_ANSWER;
         waitReq_nxt = 1'b0;
         resp_nxt    = 2'h0;
         unique case (address)
            SYSCFG_IDX: begin
               // R4 writable configuration
               if (write) begin
                  sysCfg_nxt = (sysCfg_r & ~(be_mask(byteenable) & SYSCFG_WMASK))
                             | (writedata & be_mask(byteenable) & SYSCFG_WMASK);
               end
               rdata_nxt = sysCfg_r;
            end
            STATUS_IDX: begin
               // R7 writes ignored
               rdata_nxt = statusWord;
            end
            default: begin
               rdata_nxt = 32'h0;
               resp_nxt  = 2'h2;
            end
         endcase
         if (write) begin
            rdata_nxt = 32'h0;
         end
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         bus_r    <= PSSC_IDLE;
         waitReq_r <= 1'b1;
         sysCfg_r <= SYSCFG_RESET;
         rdata_r  <= 32'h0;
         resp_r   <= 2'h0;
      end else begin
         bus_r    <= bus_nxt;
         waitReq_r <= waitReq_nxt;
         sysCfg_r <= sysCfg_nxt;
         rdata_r  <= rdata_nxt;
         resp_r   <= resp_nxt;
      end
   end

   assign readdata    = rdata_r;
   assign response    = resp_r;
   // own flop, so the port carries no decode glitch
   assign waitrequest = waitReq_r;

   // R5 separate field per channel
   assign gainCode[0] = sysCfg_r[GAIN0_LSB +: 3];
   assign gainCode[1] = sysCfg_r[GAIN1_LSB +: 3];

   // one decoder per channel, nothing shared between them
   for (genvar ch = 0; ch < 2; ch++) begin : g_gain
      pssc_gain_decode u_dec (
         .gainCode  (gainCode[ch]),
         .gainShift (gainDec[ch])
      );
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         gainShiftCh0    <= 3'h0;
         gainShiftCh1    <= 3'h0;
         convResetCtl    <= 2'h0;
         convShutdownCtl <= 2'h0;
         refTrim         <= SYSCFG_RESET[REFTRIM_LSB +: 8];
         autoTxEnable    <= 1'b0;
      end else begin
         // R6 decoded gain to front end
         gainShiftCh0    <= gainDec[0];
         gainShiftCh1    <= gainDec[1];
         convResetCtl    <= sysCfg_r[CNVRST_LSB +: 2];
         convShutdownCtl <= sysCfg_r[CNVSHDN_LSB +: 2];
         refTrim         <= sysCfg_r[REFTRIM_LSB +: 8];
         autoTxEnable    <= sysCfg_r[AUTOTX_BIT];
      end
   end

   property p_io_level;
      @(posedge mclk) disable iff (!nrst)
         // the release edge itself still holds reset, so start one edge later
         nrst |=> statusWord[6:3] == $past(ioInputLevel);
   endproperty
   a_io_level: assert property (p_io_level) else $error("io level not shown"); // R1

   property p_strap_hold;
      @(posedge mclk) disable iff (!nrst)
         strapDone_r |=> $stable(strap_r) && $stable(multi_r);
   endproperty
   a_strap_hold: assert property (p_strap_hold) else $error("strap moved"); // R7

   property p_mode;
      @(posedge mclk) disable iff (!nrst)
         // straps are caught on the first edge that sees reset released
         !strapDone_r && nrst
            |=> multi_r == !$past(modePin) && strap_r == $past(addrStrapPins);
   endproperty
   a_mode: assert property (p_mode) else $error("strap latch wrong"); // R3

   sequence s_cfg_write;
      write && waitrequest && bus_r == PSSC_IDLE && address == SYSCFG_IDX
         && byteenable == 4'hf;
   endsequence
   property p_cfg_write;
      @(posedge mclk) disable iff (!nrst)
         s_cfg_write
            |=> sysCfg_r == ($past(writedata) & SYSCFG_WMASK | $past(sysCfg_r) & ~SYSCFG_WMASK);
   endproperty
   a_cfg_write: assert property (p_cfg_write) else $error("config write lost"); // R4

   property p_gain_ch;
      @(posedge mclk) disable iff (!nrst)
         sysCfg_r[GAIN0_LSB +: 3] <= GAIN_MAX_CODE
            |=> gainShiftCh0 == $past(sysCfg_r[GAIN0_LSB +: 3]);
   endproperty
   a_gain_ch: assert property (p_gain_ch) else $error("ch0 gain wrong"); // R5

   property p_gain_undef;
      @(posedge mclk) disable iff (!nrst)
         sysCfg_r[GAIN1_LSB +: 3] > GAIN_MAX_CODE |=> gainShiftCh1 == 3'h0;
   endproperty
   a_gain_undef: assert property (p_gain_undef) else $error("undefined gain not one"); // R6

   property p_status_read;
      @(posedge mclk) disable iff (!nrst)
         read && bus_r == PSSC_IDLE && address == STATUS_IDX
            |=> !waitrequest && readdata == $past(statusWord);
   endproperty
   a_status_read: assert property (p_status_read) else $error("status read wrong"); // R2

   property p_status_nowrite;
      @(posedge mclk) disable iff (!nrst)
         write && address == STATUS_IDX |=> $stable(sysCfg_r);
   endproperty
   a_status_nowrite: assert property (p_status_nowrite) else $error("status write had effect"); // R7

   // request handshake: exactly one answer cycle per taken request
   sequence s_taken;
      (read || write) && bus_r == PSSC_IDLE;
   endsequence
   sequence s_answer;
      !waitrequest ##1 waitrequest;
   endsequence
   property p_answer_one;
      @(posedge mclk) disable iff (!nrst)
         s_taken |=> s_answer;
   endproperty
   a_answer_one: assert property (p_answer_one) else $error("answer not one cycle"); // R4

   property p_wait_idle;
      @(posedge mclk) disable iff (!nrst)
         !read && !write && waitrequest |=> waitrequest;
   endproperty
   a_wait_idle: assert property (p_wait_idle) else $error("answer without request"); // R4

   property p_cfg_read;
      @(posedge mclk) disable iff (!nrst)
         read && bus_r == PSSC_IDLE && is_cfg(address)
            |=> !waitrequest && readdata == $past(sysCfg_r);
   endproperty
   a_cfg_read: assert property (p_cfg_read) else $error("config read wrong"); // R4

   property p_unmapped;
      @(posedge mclk) disable iff (!nrst)
         (read || write) && bus_r == PSSC_IDLE && !is_cfg(address) && !is_status(address)
            |=> response == 2'h2 && readdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access answered"); // R4

   property p_write_rdata;
      @(posedge mclk) disable iff (!nrst)
         write && bus_r == PSSC_IDLE |=> readdata == 32'h0;
   endproperty
   a_write_rdata: assert property (p_write_rdata) else $error("write answer carried data"); // R7

   property p_gain_ch1;
      @(posedge mclk) disable iff (!nrst)
         sysCfg_r[GAIN1_LSB +: 3] <= GAIN_MAX_CODE
            |=> gainShiftCh1 == $past(sysCfg_r[GAIN1_LSB +: 3]);
   endproperty
   a_gain_ch1: assert property (p_gain_ch1) else $error("ch1 gain wrong"); // R5

   property p_gain_undef0;
      @(posedge mclk) disable iff (!nrst)
         sysCfg_r[GAIN0_LSB +: 3] > GAIN_MAX_CODE |=> gainShiftCh0 == 3'h0;
   endproperty
   a_gain_undef0: assert property (p_gain_undef0) else $error("ch0 undefined gain"); // R6

   // front end controls follow the register one edge later
   property p_ctl_copy;
      @(posedge mclk) disable iff (!nrst)
         1'b1 |=> convResetCtl == $past(sysCfg_r[CNVRST_LSB +: 2])
            && convShutdownCtl == $past(sysCfg_r[CNVSHDN_LSB +: 2])
            && refTrim == $past(sysCfg_r[REFTRIM_LSB +: 8])
            && autoTxEnable == $past(sysCfg_r[AUTOTX_BIT]);
   endproperty
   a_ctl_copy: assert property (p_ctl_copy) else $error("front end control stale"); // R4

   property p_status_zero;
      @(posedge mclk) disable iff (!nrst)
         read && bus_r == PSSC_IDLE && is_status(address) |=> readdata[31:7] == 25'h0;
   endproperty
   a_status_zero: assert property (p_status_zero) else $error("status upper bits set"); // R1
endmodule : pin_strap_status_and_sysconfig

// ==== verification/pin_strap_status_and_sysconfig_test.sv ====
// self-checking bench for the strap status and system configuration bank
module pin_strap_status_and_sysconfig_test
   import pssc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk = 1'b0, nrst = 1'b0, read = 1'b0, write = 1'b0, modePin = 1'b0;
   logic [7:0]  address = 8'h00;
   logic [3:0]  byteenable = 4'hf, ioInputLevel = 4'h0;
   logic [31:0] writedata = 32'h0, readdata, q, cfg;
   logic        waitrequest, autoTxEnable;
   logic [1:0]  response, rsp, addrStrapPins = 2'h0, convResetCtl, convShutdownCtl;
   logic [2:0]  gainShiftCh0, gainShiftCh1;
   logic [7:0]  refTrim;
   int          fails = 0, comparisons = 0;
   always #12.5 mclk = ~mclk;
   pin_strap_status_and_sysconfig dut (.mclk(mclk), .nrst(nrst), .address(address),
      .read(read), .write(write), .byteenable(byteenable), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest), .response(response),
      .ioInputLevel(ioInputLevel), .addrStrapPins(addrStrapPins), .modePin(modePin),
      .gainShiftCh0(gainShiftCh0), .gainShiftCh1(gainShiftCh1),
      .convResetCtl(convResetCtl), .convShutdownCtl(convShutdownCtl),
      .refTrim(refTrim), .autoTxEnable(autoTxEnable));
   task automatic test_done;
      $display("checks %0d mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : test_done
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // one avalon transfer; waits for the answer edge, no cycle count assumed
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] be);
      int n;
      @(posedge mclk);
      read <= ~w;
      write <= w;
      address <= a;
      writedata <= d;
      byteenable <= be;
      for (n = 0; n < 50; n++) begin
         @(posedge mclk);
         if (waitrequest === 1'b0) break;
      end
      if (n == 50) begin
         fails++;
         test_done();
      end
      q = readdata;
      rsp = response;
      read <= 1'b0;
      write <= 1'b0;
   endtask : bus
   // straps are held past release, then disturbed to prove they were latched
   task automatic rst(input logic [1:0] a, input logic m);
      @(posedge mclk);
      nrst <= 1'b0;
      addrStrapPins <= a;
      modePin <= m;
      repeat (2) @(posedge mclk);
      nrst <= 1'b1;
      repeat (2) @(posedge mclk);
      addrStrapPins <= ~a;
      modePin <= ~m;
   endtask : rst
   function automatic logic [31:0] stat(logic [3:0] io, logic [1:0] a, logic m);
      return {25'h0, io, a, ~m};
   endfunction : stat
   function automatic logic [2:0] gexp(logic [2:0] c);
      return (c > 3'h5) ? 3'h0 : c;
   endfunction : gexp
   initial begin
      void'($urandom(32'hab89));
      rst(2'h2, 1'b0);
      bus(1'b0, STATUS_IDX, 32'h0, 4'hf);
      chk(q, stat(4'h0, 2'h2, 1'b0));
      bus(1'b0, SYSCFG_IDX, 32'h0, 4'hf);
      chk(q, SYSCFG_RESET);
      for (int i = 0; i < 24; i++) begin
         cfg = $urandom;
         if (i < 8) cfg[5:0] = {3'(7 - i), 3'(i)};
         bus(1'b1, SYSCFG_IDX, cfg, 4'hf);
         bus(1'b0, SYSCFG_IDX, 32'h0, 4'hf);
         chk(q, cfg & SYSCFG_WMASK);
         chk(32'({gainShiftCh1, gainShiftCh0}), 32'({gexp(cfg[5:3]), gexp(cfg[2:0])}));
         chk(32'({autoTxEnable, refTrim, convShutdownCtl, convResetCtl}),
             32'({cfg[24], cfg[23:16], cfg[11:10], cfg[9:8]}));
      end
      bus(1'b1, SYSCFG_IDX, 32'hffff_ffff, 4'h2);
      bus(1'b0, SYSCFG_IDX, 32'h0, 4'hf);
      chk(q, (cfg & SYSCFG_WMASK & ~32'h0000_ff00) | 32'h0000_0f00);
      for (int i = 0; i < 10; i++) begin
         ioInputLevel <= (i == 0) ? 4'hf : 4'($urandom);
         addrStrapPins <= 2'($urandom);
         repeat (3) @(posedge mclk);
         bus(1'b1, STATUS_IDX, 32'hffff_ffff, 4'hf);
         bus(1'b0, STATUS_IDX, 32'h0, 4'hf);
         chk(q, stat(ioInputLevel, 2'h2, 1'b0));
      end
      bus(1'b0, 8'h10, 32'h0, 4'hf);
      chk(q, 32'h0);
      chk(32'(rsp), 32'h2);
      rst(2'h1, 1'b1);
      bus(1'b0, STATUS_IDX, 32'h0, 4'hf);
      chk(q, stat(ioInputLevel, 2'h1, 1'b1));
      bus(1'b0, SYSCFG_IDX, 32'h0, 4'hf);
      chk(q, SYSCFG_RESET);
      chk(32'(rsp), 32'h0);
      chk(32'({gainShiftCh1, gainShiftCh0, convShutdownCtl, convResetCtl, autoTxEnable}),
          32'h0);
      chk(32'(refTrim), 32'(SYSCFG_RESET[REFTRIM_LSB +: 8]));
      test_done();
   end
endmodule : pin_strap_status_and_sysconfig_test
